/* verilog/accel_regs_pkg.sv */
package accel_regs_pkg;

  // Register indices; the bus byte address is four times the index
  localparam logic [5:0] IDX_LAST_RO = 6'h0E;
  localparam logic [5:0] IDX_SOFT_RESET = 6'h14;
  localparam logic [5:0] IDX_INTERRUPT_LATCH_CONTROL = 6'h21;
  localparam logic [5:0] IDX_LOW_ACCEL_DURATION = 6'h22;
  localparam logic [5:0] IDX_LOW_ACCEL_THRESHOLD = 6'h23;
  localparam logic [5:0] IDX_ACCEL_HYSTERESIS_CONFIG = 6'h24;
  localparam logic [5:0] IDX_HIGH_ACCEL_DURATION = 6'h25;
  localparam logic [5:0] IDX_HIGH_ACCEL_THRESHOLD = 6'h26;
  localparam logic [5:0] IDX_MOTION_DURATION_CONFIG = 6'h27;
  localparam logic [5:0] IDX_SLOPE_THRESHOLD = 6'h28;
  localparam logic [5:0] IDX_STILL_MOTION_THRESHOLD = 6'h29;
  localparam logic [5:0] IDX_KNOCK_TIMING_CONFIG = 6'h2A;
  localparam logic [5:0] IDX_KNOCK_THRESHOLD_CONFIG = 6'h2B;
  localparam logic [5:0] IDX_ATTITUDE_MODE_CONFIG = 6'h2C;
  localparam logic [5:0] IDX_ATTITUDE_ANGLE_CONFIG = 6'h2D;
  localparam logic [5:0] IDX_LEVEL_ANGLE_CONFIG = 6'h2E;
  localparam logic [5:0] IDX_LEVEL_HOLD_CONFIG = 6'h2F;
  localparam logic [5:0] IDX_QUEUE_WATERMARK_CONFIG = 6'h30;
  localparam logic [5:0] IDX_RESERVED_BLOCK_31 = 6'h31;
  localparam logic [5:0] IDX_SELF_CHECK_CONTROL = 6'h32;
  localparam logic [5:0] IDX_NONVOLATILE_CONTROL = 6'h33;
  localparam logic [5:0] IDX_HOST_INTERFACE_CONFIG = 6'h34;
  localparam logic [5:0] IDX_RESERVED_BLOCK_35 = 6'h35;
  localparam logic [5:0] IDX_OFFSET_CALIBRATION_CONTROL = 6'h36;
  localparam logic [5:0] IDX_OFFSET_TARGET_CONFIG = 6'h37;
  localparam logic [5:0] IDX_OFFSET_VALUE_X = 6'h38;
  localparam logic [5:0] IDX_OFFSET_VALUE_Y = 6'h39;
  localparam logic [5:0] IDX_OFFSET_VALUE_Z = 6'h3A;
  localparam logic [5:0] IDX_QUEUE_MODE_CONFIG = 6'h3E;
  localparam logic [5:0] IDX_QUEUE_READ_PORT = 6'h3F;
  localparam logic [5:0] IDX_CFG_FIRST = 6'h0F;
  localparam int CFG_COUNT = 48;

  // Reset values of the writable registers that are not zero
  localparam logic [7:0] RST_RANGE = 8'h03;
  localparam logic [7:0] RST_BANDWIDTH = 8'h0F;
  localparam logic [7:0] RST_PIN_CONFIG = 8'h05;
  localparam logic [7:0] RST_LOW_ACCEL_DURATION = 8'h09;
  localparam logic [7:0] RST_LOW_ACCEL_THRESHOLD = 8'h30;
  localparam logic [7:0] RST_ACCEL_HYSTERESIS_CONFIG = 8'h81;
  localparam logic [7:0] RST_HIGH_ACCEL_DURATION = 8'h0F;
  localparam logic [7:0] RST_HIGH_ACCEL_THRESHOLD = 8'hC0;
  localparam logic [7:0] RST_SLOPE_THRESHOLD = 8'h14;
  localparam logic [7:0] RST_STILL_MOTION_THRESHOLD = 8'h14;
  localparam logic [7:0] RST_KNOCK_TIMING_CONFIG = 8'h04;
  localparam logic [7:0] RST_KNOCK_THRESHOLD_CONFIG = 8'h0A;
  localparam logic [7:0] RST_ATTITUDE_MODE_CONFIG = 8'h18;
  localparam logic [7:0] RST_ATTITUDE_ANGLE_CONFIG = 8'h08;
  localparam logic [7:0] RST_LEVEL_ANGLE_CONFIG = 8'h08;
  localparam logic [7:0] RST_LEVEL_HOLD_CONFIG = 8'h11;
  localparam logic [7:0] RST_SPARE_3D = 8'hFF;

  // Key that starts a complete software reset
  localparam logic [7:0] SOFT_RESET_KEY = 8'hB6;

  // Trigger bit positions
  localparam int INT_CLEAR_BIT = 7;
  localparam int NVM_LOAD_BIT = 3;
  localparam int NVM_PROG_BIT = 1;
  localparam int OFFSET_RESET_BIT = 7;
  localparam int CAL_TRIGGER_LSB = 5;

endpackage

/* verilog/accel_register_space.sv */
`timescale 1ns/1ps
// Operation
// - Every register is eight bits wide
// - Sixty-four register locations, addresses 0x00 to 0x3F
// - Writes to reserved bits change nothing
// - Reserved bits read with no guaranteed value
// - Addresses 0x00 to 0x0E ignore writes
// - Trigger bits are write-only, read zero
// - Writing 0xB6 at 0x14 restores defaults
module accel_register_space #(
  // Arbitrary identification value
  parameter logic [7:0] CHIP_IDENT = 8'h5A
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  input wire logic [111:0] STATUS_BYTES,
  input wire logic [3:0] NVM_REMAIN,
  input wire logic NVM_READY,
  input wire logic CAL_READY,
  input wire logic [7:0] QUEUE_DATA,
  output logic QUEUE_POP,
  output logic INT_LATCH_CLEAR,
  output logic SOFT_RESET,
  output logic NVM_LOAD,
  output logic NVM_PROG,
  output logic OFFSET_RESET,
  output logic [1:0] CAL_START,
  output logic [383:0] CFG_BYTES
);

  ////////////////////////////////////////////////////////////////////////
  // Writable bit mask and default of each location

  function automatic logic [7:0] write_mask(input logic [5:0] idx);
    logic [7:0] m;
    m = 8'h00;
    if (idx == 6'h0F) m = 8'h0F;
    else if (idx == 6'h10) m = 8'h1F;
    else if (idx == 6'h11) m = 8'hFE;
    else if (idx == 6'h12) m = 8'h60;
    else if (idx == 6'h13) m = 8'hC0;
    else if (idx == 6'h16) m = 8'hF7;
    else if (idx == 6'h17) m = 8'h7F;
    else if (idx == 6'h18) m = 8'h0F;
    else if (idx == 6'h19) m = 8'hFF;
    else if (idx == 6'h1A) m = 8'hE7;
    else if (idx == 6'h1B) m = 8'hFF;
    else if (idx == 6'h1E) m = 8'h3F;
    else if (idx == 6'h20) m = 8'h0F;
    else if (idx == accel_regs_pkg::IDX_INTERRUPT_LATCH_CONTROL) m = 8'h0F;
    else if (idx == accel_regs_pkg::IDX_LOW_ACCEL_DURATION) m = 8'hFF;
    else if (idx == accel_regs_pkg::IDX_LOW_ACCEL_THRESHOLD) m = 8'hFF;
    else if (idx == accel_regs_pkg::IDX_ACCEL_HYSTERESIS_CONFIG) m = 8'hC7;
    else if (idx == accel_regs_pkg::IDX_HIGH_ACCEL_DURATION) m = 8'hFF;
    else if (idx == accel_regs_pkg::IDX_HIGH_ACCEL_THRESHOLD) m = 8'hFF;
    else if (idx == accel_regs_pkg::IDX_MOTION_DURATION_CONFIG) m = 8'hFF;
    else if (idx == accel_regs_pkg::IDX_SLOPE_THRESHOLD) m = 8'hFF;
    else if (idx == accel_regs_pkg::IDX_STILL_MOTION_THRESHOLD) m = 8'hFF;
    else if (idx == accel_regs_pkg::IDX_KNOCK_TIMING_CONFIG) m = 8'hC7;
    else if (idx == accel_regs_pkg::IDX_KNOCK_THRESHOLD_CONFIG) m = 8'hDF;
    else if (idx == accel_regs_pkg::IDX_ATTITUDE_MODE_CONFIG) m = 8'h7F;
    else if (idx == accel_regs_pkg::IDX_ATTITUDE_ANGLE_CONFIG) m = 8'h7F;
    else if (idx == accel_regs_pkg::IDX_LEVEL_ANGLE_CONFIG) m = 8'h3F;
    else if (idx == accel_regs_pkg::IDX_LEVEL_HOLD_CONFIG) m = 8'h37;
    else if (idx == accel_regs_pkg::IDX_QUEUE_WATERMARK_CONFIG) m = 8'h3F;
    else if (idx == accel_regs_pkg::IDX_SELF_CHECK_CONTROL) m = 8'h17;
    else if (idx == accel_regs_pkg::IDX_NONVOLATILE_CONTROL) m = 8'h01;
    else if (idx == accel_regs_pkg::IDX_HOST_INTERFACE_CONFIG) m = 8'h07;
    else if (idx == accel_regs_pkg::IDX_OFFSET_CALIBRATION_CONTROL) m = 8'h07;
    else if (idx == accel_regs_pkg::IDX_OFFSET_TARGET_CONFIG) m = 8'h7F;
    else if (idx >= accel_regs_pkg::IDX_OFFSET_VALUE_X && idx <= 6'h3D) m = 8'hFF;
    else if (idx == accel_regs_pkg::IDX_QUEUE_MODE_CONFIG) m = 8'hC3;
    return m;
  endfunction

  function automatic logic [7:0] default_value(input logic [5:0] idx);
    logic [7:0] v;
    v = 8'h00;
    if (idx == 6'h0F) v = accel_regs_pkg::RST_RANGE;
    else if (idx == 6'h10) v = accel_regs_pkg::RST_BANDWIDTH;
    else if (idx == 6'h20) v = accel_regs_pkg::RST_PIN_CONFIG;
    else if (idx == accel_regs_pkg::IDX_LOW_ACCEL_DURATION) v = accel_regs_pkg::RST_LOW_ACCEL_DURATION;
    else if (idx == accel_regs_pkg::IDX_LOW_ACCEL_THRESHOLD) v = accel_regs_pkg::RST_LOW_ACCEL_THRESHOLD;
    else if (idx == accel_regs_pkg::IDX_ACCEL_HYSTERESIS_CONFIG) v = accel_regs_pkg::RST_ACCEL_HYSTERESIS_CONFIG;
    else if (idx == accel_regs_pkg::IDX_HIGH_ACCEL_DURATION) v = accel_regs_pkg::RST_HIGH_ACCEL_DURATION;
    else if (idx == accel_regs_pkg::IDX_HIGH_ACCEL_THRESHOLD) v = accel_regs_pkg::RST_HIGH_ACCEL_THRESHOLD;
    else if (idx == accel_regs_pkg::IDX_SLOPE_THRESHOLD) v = accel_regs_pkg::RST_SLOPE_THRESHOLD;
    else if (idx == accel_regs_pkg::IDX_STILL_MOTION_THRESHOLD) v = accel_regs_pkg::RST_STILL_MOTION_THRESHOLD;
    else if (idx == accel_regs_pkg::IDX_KNOCK_TIMING_CONFIG) v = accel_regs_pkg::RST_KNOCK_TIMING_CONFIG;
    else if (idx == accel_regs_pkg::IDX_KNOCK_THRESHOLD_CONFIG) v = accel_regs_pkg::RST_KNOCK_THRESHOLD_CONFIG;
    else if (idx == accel_regs_pkg::IDX_ATTITUDE_MODE_CONFIG) v = accel_regs_pkg::RST_ATTITUDE_MODE_CONFIG;
    else if (idx == accel_regs_pkg::IDX_ATTITUDE_ANGLE_CONFIG) v = accel_regs_pkg::RST_ATTITUDE_ANGLE_CONFIG;
    else if (idx == accel_regs_pkg::IDX_LEVEL_ANGLE_CONFIG) v = accel_regs_pkg::RST_LEVEL_ANGLE_CONFIG;
    else if (idx == accel_regs_pkg::IDX_LEVEL_HOLD_CONFIG) v = accel_regs_pkg::RST_LEVEL_HOLD_CONFIG;
    else if (idx == 6'h3D) v = accel_regs_pkg::RST_SPARE_3D;
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic ack_q;
  logic [31:0] dat_q;
  logic [7:0] cfg_q [0:63];
  logic pop_q;
  logic int_clr_q;
  logic soft_q;
  logic nvm_load_q;
  logic nvm_prog_q;
  logic ofs_rst_q;
  logic [1:0] cal_q;

  wire access = CYC_I && STB_I && !ack_q;
  // word index covers all 64 locations
  wire [5:0] idx = ADR_I[7:2];
  // only the low byte lane carries data
  wire wr_en = access && WE_I && SEL_I[0];
  wire rd_en = access && !WE_I;
  wire [7:0] wdat = DAT_I[7:0];
  wire [7:0] mask = write_mask(idx);
  wire soft_hit = wr_en && idx == accel_regs_pkg::IDX_SOFT_RESET && wdat == accel_regs_pkg::SOFT_RESET_KEY;
  // reserved and read-only bits keep old value
  wire [7:0] merged = (wdat & mask) | (cfg_q[idx] & ~mask);
  wire wr_latch = wr_en && idx == accel_regs_pkg::IDX_INTERRUPT_LATCH_CONTROL;
  wire wr_nvm = wr_en && idx == accel_regs_pkg::IDX_NONVOLATILE_CONTROL;
  wire wr_cal = wr_en && idx == accel_regs_pkg::IDX_OFFSET_CALIBRATION_CONTROL;

  ////////////////////////////////////////////////////////////////////////
  // Read selection

  wire [7:0] status_byte = STATUS_BYTES[8 * (idx - 6'h01) +: 8];
  wire [7:0] nvm_view = {NVM_REMAIN, 1'b0, NVM_READY, 1'b0, cfg_q[accel_regs_pkg::IDX_NONVOLATILE_CONTROL][0]};
  wire [7:0] cal_view = {3'b000, CAL_READY, 1'b0, cfg_q[accel_regs_pkg::IDX_OFFSET_CALIBRATION_CONTROL][2:0]};
  // reserved bits read as zero here
  wire [7:0] cfg_view = cfg_q[idx] & mask;
  wire [7:0] rd_byte;
  // trigger bits are never stored, so read zero
  assign rd_byte = (idx == 6'h00) ? CHIP_IDENT :
                   (idx <= accel_regs_pkg::IDX_LAST_RO) ? status_byte :
                   (idx == accel_regs_pkg::IDX_NONVOLATILE_CONTROL) ? nvm_view :
                   (idx == accel_regs_pkg::IDX_OFFSET_CALIBRATION_CONTROL) ? cal_view :
                   (idx == accel_regs_pkg::IDX_QUEUE_READ_PORT) ? QUEUE_DATA :
                   cfg_view;

  ////////////////////////////////////////////////////////////////////////
  // Wishbone answer: one wait state

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end
    else
    begin
      ack_q <= access;
      if (rd_en)
        dat_q <= {24'h000000, rd_byte};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register storage

  always_ff @(posedge REF_CLK)
  begin
    if (RST || soft_hit)
    begin
      for (int i = 0; i < 64; i++)
        cfg_q[i] <= default_value(6'(i));
    end
    // read-only range has an all-zero mask
    else if (wr_en)
      cfg_q[idx] <= merged;
  end

  ////////////////////////////////////////////////////////////////////////
  // Trigger pulses

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      pop_q <= 1'b0;
      int_clr_q <= 1'b0;
      soft_q <= 1'b0;
      nvm_load_q <= 1'b0;
      nvm_prog_q <= 1'b0;
      ofs_rst_q <= 1'b0;
      cal_q <= 2'b00;
    end
    else
    begin
      pop_q <= rd_en && idx == accel_regs_pkg::IDX_QUEUE_READ_PORT;
      int_clr_q <= wr_latch && wdat[accel_regs_pkg::INT_CLEAR_BIT];
      soft_q <= soft_hit;
      nvm_load_q <= wr_nvm && wdat[accel_regs_pkg::NVM_LOAD_BIT];
      nvm_prog_q <= wr_nvm && wdat[accel_regs_pkg::NVM_PROG_BIT];
      ofs_rst_q <= wr_cal && wdat[accel_regs_pkg::OFFSET_RESET_BIT];
      cal_q <= wr_cal ? wdat[accel_regs_pkg::CAL_TRIGGER_LSB +: 2] : 2'b00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign ACK_O = ack_q;
  assign DAT_O = dat_q;
  assign QUEUE_POP = pop_q;
  assign INT_LATCH_CLEAR = int_clr_q;
  assign SOFT_RESET = soft_q;
  assign NVM_LOAD = nvm_load_q;
  assign NVM_PROG = nvm_prog_q;
  assign OFFSET_RESET = ofs_rst_q;
  assign CAL_START = cal_q;

  genvar g;
  generate
    for (g = 0; g < accel_regs_pkg::CFG_COUNT; g++)
    begin : cfg_out
      assign CFG_BYTES[8 * g +: 8] = cfg_q[g + 15];
    end
  endgenerate

endmodule

/* tb/accel_register_space_properties.sv */
`timescale 1ns/1ps
module accel_register_space_properties (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  input wire logic [31:0] DAT_O,
  input wire logic ACK_O,
  input wire logic INT_LATCH_CLEAR,
  input wire logic SOFT_RESET,
  input wire logic QUEUE_POP,
  input wire logic NVM_LOAD,
  input wire logic NVM_PROG,
  input wire logic OFFSET_RESET,
  input wire logic [1:0] CAL_START,
  input wire logic [383:0] CFG_BYTES
);
  wire take = CYC_I && STB_I && !ACK_O;
  wire wr = take && WE_I && SEL_I[0];
  wire [5:0] idx = ADR_I[7:2];
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  property p_ack; take |=> ACK_O ##1 !ACK_O; endproperty
  a_ack: assert property (p_ack) else $error("ack not a single cycle after request");
  property p_hi; ACK_O |-> DAT_O[31:8] == 24'h000000; endproperty
  a_hi: assert property (p_hi) else $error("read data wider than a byte");
  property p_ro; wr && idx <= 6'h0E |=> $stable(CFG_BYTES); endproperty
  a_ro: assert property (p_ro) else $error("low place write changed storage");
  property p_rsvd; wr && (idx == 6'h31 || idx == 6'h35) |=> $stable(CFG_BYTES); endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved place write changed storage");
  property p_trig; ACK_O && !WE_I && idx == 6'h21 |-> !DAT_O[7]; endproperty
  a_trig: assert property (p_trig) else $error("trigger bit read as one");
  property p_clr; wr && idx == 6'h21 && DAT_I[7] |=> INT_LATCH_CLEAR; endproperty
  a_clr: assert property (p_clr) else $error("no latch clear pulse");
  property p_soft; wr && idx == 6'h14 && DAT_I[7:0] == 8'hB6 |=> SOFT_RESET && CFG_BYTES[159:152] == 8'h09; endproperty
  a_soft: assert property (p_soft) else $error("key write did not restore defaults");
  property p_def; $fell(RST) |-> CFG_BYTES[7:0] == 8'h03 && CFG_BYTES[239:232] == 8'h18; endproperty
  a_def: assert property (p_def) else $error("defaults missing after reset");
  property p_pop; take && !WE_I && idx == 6'h3F |=> QUEUE_POP; endproperty
  a_pop: assert property (p_pop) else $error("no queue pop pulse");
  property p_nvm; wr && idx == 6'h33 && DAT_I[3] && DAT_I[1] |=> NVM_LOAD && NVM_PROG; endproperty
  a_nvm: assert property (p_nvm) else $error("no nonvolatile launch pulses");
  property p_ofs; wr && idx == 6'h36 && DAT_I[7] |=> OFFSET_RESET; endproperty
  a_ofs: assert property (p_ofs) else $error("no offset reset pulse");
  property p_cal; wr && idx == 6'h36 |=> CAL_START == $past(DAT_I[6:5]); endproperty
  a_cal: assert property (p_cal) else $error("calibration start pulse wrong");
endmodule

/* tb/wb_host_model.sv */
`timescale 1ns/1ps
module wb_host_model (
  input wire logic clk,
  input wire logic ack,
  input wire logic [31:0] dat_r,
  output logic cyc = 1'b0,
  output logic stb = 1'b0,
  output logic we = 1'b0,
  output logic [7:0] adr = 8'h00,
  output logic [3:0] sel = 4'h0,
  output logic [31:0] dat_w = 32'h00000000
);
  task automatic access(input logic w, input logic [5:0] ix, input logic [7:0] d, input logic [7:0] m,
    output logic [7:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {ix, 2'b00};
    sel <= 4'hF;
    dat_w <= {24'h000000, d & m};
    do @(posedge clk); while (ack !== 1'b1);
    q = dat_r[7:0] & m;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
endmodule

/* tb/tb_accel_register_space.sv */
`timescale 1ns/1ps
module tb_accel_register_space;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic cyc, stb, we, ack;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_w, dat_r;
  logic [383:0] cfg;
  logic [7:0] qdata = 8'h3C;
  logic [7:0] q;
  int err_count = 0;
  int n_checks = 0;
  always #5 ref_clk = ~ref_clk;
  accel_register_space u_accel_register_space (.REF_CLK(ref_clk), .RST(rst), .CYC_I(cyc), .STB_I(stb),
    .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack),
    .STATUS_BYTES({8'hA5, 104'h0}), .NVM_REMAIN(4'hF), .NVM_READY(1'b0), .CAL_READY(1'b1),
    .QUEUE_DATA(qdata), .QUEUE_POP(), .INT_LATCH_CLEAR(), .SOFT_RESET(), .NVM_LOAD(), .NVM_PROG(),
    .OFFSET_RESET(), .CAL_START(), .CFG_BYTES(cfg));
  wb_host_model u_host (.clk(ref_clk), .ack(ack), .dat_r(dat_r), .cyc(cyc), .stb(stb), .we(we),
    .adr(adr), .sel(sel), .dat_w(dat_w));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////
  task automatic t_defaults;
    logic [5:0] ix [7] = '{6'h22, 6'h24, 6'h26, 6'h2C, 6'h2F, 6'h33, 6'h36};
    logic [7:0] dv [7] = '{8'h09, 8'h81, 8'hC0, 8'h18, 8'h11, 8'hF0, 8'h10};
    logic [7:0] mk [7] = '{8'hFF, 8'hC7, 8'hFF, 8'h7F, 8'h37, 8'hFF, 8'hF7};
    for (int i = 0; i < 7; i++)
    begin
      u_host.access(1'b0, ix[i], 8'h00, mk[i], q);
      chk("default", dv[i] & mk[i], q);
    end
  endtask
  task automatic t_rw;
    u_host.access(1'b1, 6'h38, 8'h5A, 8'hFF, q);
    u_host.access(1'b0, 6'h38, 8'h00, 8'hFF, q);
    chk("offset x", 8'h5A, q);
    u_host.access(1'b1, 6'h3E, 8'hFF, 8'hFF, q);
    u_host.access(1'b1, 6'h31, 8'hAA, 8'hFF, q);
    u_host.access(1'b0, 6'h3E, 8'h00, 8'hC3, q);
    chk("queue mode", 8'hC3, q);
    u_host.access(1'b1, 6'h0E, 8'h00, 8'hFF, q);
    u_host.access(1'b0, 6'h0E, 8'h00, 8'hFF, q);
    chk("read only", 8'hA5, q);
    @(posedge ref_clk) qdata <= 8'hC3;
    u_host.access(1'b0, 6'h3F, 8'h00, 8'hFF, q);
    chk("queue data", 8'hC3, q);
  endtask
  task automatic t_trig;
    u_host.access(1'b1, 6'h21, 8'h8F, 8'hFF, q);
    u_host.access(1'b0, 6'h21, 8'h00, 8'h8F, q);
    chk("latch control", 8'h0F, q);
    u_host.access(1'b1, 6'h22, 8'h55, 8'hFF, q);
    u_host.access(1'b1, 6'h14, 8'hB5, 8'hFF, q);
    u_host.access(1'b0, 6'h22, 8'h00, 8'hFF, q);
    chk("wrong key", 8'h55, q);
    u_host.access(1'b1, 6'h14, 8'hB6, 8'hFF, q);
    u_host.access(1'b0, 6'h14, 8'h00, 8'hFF, q);
    chk("reset register", 8'h00, q);
    u_host.access(1'b0, 6'h22, 8'h00, 8'hFF, q);
    chk("after key", 8'h09, q);
    u_host.access(1'b1, 6'h36, 8'hE7, 8'hFF, q);
    u_host.access(1'b0, 6'h36, 8'h00, 8'hF7, q);
    chk("calibration", 8'h17, q);
    u_host.access(1'b1, 6'h33, 8'h0A, 8'hFF, q);
    u_host.access(1'b0, 6'h33, 8'h00, 8'hFF, q);
    chk("nonvolatile", 8'hF0, q);
  endtask
  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    t_defaults();
    t_rw();
    t_trig();
    end_sim();
  end
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    err_count++;
    end_sim();
  end
endmodule
bind accel_register_space accel_register_space_properties u_props (.REF_CLK, .RST, .CYC_I, .STB_I, .WE_I,
  .ADR_I, .SEL_I, .DAT_I, .DAT_O, .ACK_O, .INT_LATCH_CLEAR, .SOFT_RESET, .QUEUE_POP, .NVM_LOAD, .NVM_PROG,
  .OFFSET_RESET, .CAL_START, .CFG_BYTES);
